// [cec_pkg.sv]
// Shared constants for the configuration-memory error checker and its controller
`default_nettype none
package cec_pkg;
	localparam int SYN_W = 16;
	localparam int MSG_W = 46;
	localparam int TYPE_W = 4;
	localparam int LOC_W = 26;
	localparam int INJ_W = 21;
	localparam int INJ_TGT_W = 19;
	// Report layout: type, location, syndrome
	localparam int MSG_SYN_LO = 0;
	localparam int MSG_LOC_LO = 16;
	localparam int MSG_TYPE_LO = 42;
	localparam int INJ_TYPE_LO = 19;
	localparam logic [TYPE_W-1:0] ETYPE_SINGLE = 4'h1;
	localparam logic [TYPE_W-1:0] ETYPE_DADJ = 4'h2;
	// Check-clock divider and flag gap
	localparam int CHK_DIV = 2;
	localparam logic [1:0] CHK_DIV_LAST = 2'h1;
	localparam logic [5:0] GAP_CHK_CYCLES = 6'h20;
	typedef enum logic [1:0] {
		INSTR_NONE                     = 2'b00,
		INSTR_read_error_message_instr = 2'b01,
		INSTR_load_fault_injection_instr = 2'b10
	} cec_instr_t;
	typedef enum logic [1:0] {
		INJ_NONE   = 2'b00,
		INJ_SINGLE = 2'b01,
		INJ_DADJ   = 2'b10
	} cec_inj_t;
	// Controller register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INJ = 8'h04;
	localparam logic [7:0] OFS_JMSG_LO = 8'h08;
	localparam logic [7:0] OFS_JMSG_HI = 8'h0C;
	localparam logic [7:0] OFS_CMSG_LO = 8'h10;
	localparam logic [7:0] OFS_CMSG_HI = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
	localparam int CTRL_JREAD = 0;
	localparam int CTRL_CREAD = 1;
	localparam int CTRL_INJECT = 2;
	localparam int IRQ_FLAG = 0;
	localparam int IRQ_DONE = 1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
endpackage
`default_nettype wire

// [cec_if.sv]
// Link between the error checker and its controller
`default_nettype none
interface cec_if;
	logic [1:0] instr;
	logic       jcap;
	logic       jshift;
	logic       jupd;
	logic       tdi;
	logic       tdo;
	logic       ccap;
	logic       cshift;
	logic       csdo;
	logic       upset_flag;
	modport dev_mp (input instr, jcap, jshift, jupd, tdi, ccap, cshift, output tdo, csdo, upset_flag);
	modport host_mp (output instr, jcap, jshift, jupd, tdi, ccap, cshift, input tdo, csdo, upset_flag);
endinterface
`default_nettype wire

// [cec_device.sv]
// Error checker register set: syndrome, report, copies, shifters, fault injection
`default_nettype none
module cec_device
	import cec_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 rst_in,
	cec_if.dev_mp                     lnk,
	input  wire logic                 frame_done_in,
	input  wire logic [SYN_W-1:0]     syndrome_in,
	input  wire logic                 search_done_in,
	input  wire logic [TYPE_W-1:0]    err_type_in,
	input  wire logic [LOC_W-1:0]     err_loc_in,
	output logic                      chk_en_out,
	output logic [SYN_W-1:0]          syndrome_out,
	output logic [1:0]                inj_mode_out,
	output logic [INJ_TGT_W-1:0]      inj_target_out
);
	logic [1:0]         div_r;
	logic               chk_en_r;
	logic [SYN_W-1:0]   syndrome_r;
	logic               posted_r;
	logic [5:0]         gap_r;
	logic               flag_r;
	logic [MSG_W-1:0]   report_r;
	logic               report_valid_r;
	logic [MSG_W-1:0]   test_copy_r;
	logic [MSG_W-1:0]   core_copy_r;
	logic               test_pend_r;
	logic               core_pend_r;
	logic [MSG_W-1:0]   test_sh_r;
	logic [MSG_W-1:0]   core_sh_r;
	logic [INJ_W-1:0]   active_inj_r;
	logic [1:0]         inj_mode_r;

	wire frame_ev = frame_done_in & chk_en_r;
	wire search_ev = search_done_in & chk_en_r;
	wire syn_nz = |syndrome_r;
	wire report_we = search_ev & syn_nz;
	wire is_read = lnk.instr == INSTR_read_error_message_instr;
	wire is_inj = lnk.instr == INSTR_load_fault_injection_instr;
	wire test_cap = lnk.jcap & is_read;
	wire test_shift = lnk.jshift & (is_read | is_inj);
	wire inj_update = lnk.jupd & is_inj;
	wire test_want = report_valid_r | test_pend_r;
	wire core_want = report_valid_r | core_pend_r;
	wire test_load = test_want & ~test_cap;
	wire core_load = core_want & ~lnk.ccap;
	// location kept only for located types
	wire loc_known = (err_type_in == ETYPE_SINGLE) | (err_type_in == ETYPE_DADJ);
	wire [LOC_W-1:0] loc_masked = loc_known ? err_loc_in : {LOC_W{1'b0}};
	wire [MSG_W-1:0] report_nxt = {err_type_in, loc_masked, syndrome_r};
	// injection bits enter low 21-bit section
	wire [MSG_W-1:0] test_sh_nxt = is_inj ? {test_sh_r[MSG_W-1:INJ_W], lnk.tdi, test_sh_r[INJ_W-1:1]}
		: {lnk.tdi, test_sh_r[MSG_W-1:1]};
	wire [1:0] inj_type = active_inj_r[INJ_W-1:INJ_TYPE_LO];
	// illegal 11 decodes as no injection
	wire [1:0] inj_mode_nxt = (inj_type == INJ_SINGLE) ? INJ_SINGLE
		: (inj_type == INJ_DADJ) ? INJ_DADJ : INJ_NONE;
	// flag follows syndrome, gated by post and gap
	wire flag_nxt = syn_nz & posted_r & (gap_r == 6'h00);

	// Check-clock enable from divider
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			div_r <= 2'h0;
			chk_en_r <= 1'b0;
		end else if (div_r == CHK_DIV_LAST) begin
			div_r <= 2'h0;
			chk_en_r <= 1'b1;
		end else begin
			div_r <= div_r + 2'h1;
			chk_en_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			syndrome_r <= {SYN_W{1'b0}};
		end else if (frame_ev) begin
			syndrome_r <= syndrome_in;
		end
	end

	// flag gap counted in check cycles
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			posted_r <= 1'b0;
			gap_r <= 6'h00;
		end else begin
			if (frame_ev) begin
				posted_r <= 1'b0;
			end else if (report_we) begin
				posted_r <= 1'b1;
			end
			if (frame_ev & flag_r) begin
				gap_r <= GAP_CHK_CYCLES;
			end else if (chk_en_r & (gap_r != 6'h00)) begin
				gap_r <= gap_r - 6'h01;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// no write while syndrome is zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			report_r <= {MSG_W{1'b0}};
			report_valid_r <= 1'b0;
		end else begin
			report_valid_r <= report_we;
			if (report_we) begin
				report_r <= report_nxt;
			end
		end
	end

	// test copy one cycle after report valid
	// core copy one cycle after report valid
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			test_copy_r <= {MSG_W{1'b0}};
			core_copy_r <= {MSG_W{1'b0}};
			test_pend_r <= 1'b0;
			core_pend_r <= 1'b0;
		end else begin
			test_pend_r <= test_want & test_cap;
			core_pend_r <= core_want & lnk.ccap;
			if (test_load) begin
				test_copy_r <= report_r;
			end
			if (core_load) begin
				core_copy_r <= report_r;
			end
		end
	end

	// two read paths for the report
	// test shifter captures then shifts out
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			test_sh_r <= {MSG_W{1'b0}};
		end else if (test_cap) begin
			test_sh_r <= test_copy_r;
		end else if (test_shift) begin
			test_sh_r <= test_sh_nxt;
		end
	end

	// core shifter reached only by core side
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			core_sh_r <= {MSG_W{1'b0}};
		end else if (lnk.ccap) begin
			core_sh_r <= core_copy_r;
		end else if (lnk.cshift) begin
			core_sh_r <= {1'b0, core_sh_r[MSG_W-1:1]};
		end
	end

	// update moves full setup to active register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			active_inj_r <= {INJ_W{1'b0}};
			inj_mode_r <= INJ_NONE;
		end else begin
			if (inj_update) begin
				active_inj_r <= test_sh_r[INJ_W-1:0];
			end
			inj_mode_r <= inj_mode_nxt;
		end
	end

	assign lnk.tdo = test_sh_r[0];
	assign lnk.csdo = core_sh_r[0];
	assign lnk.upset_flag = flag_r;
	assign chk_en_out = chk_en_r;
	assign syndrome_out = syndrome_r;
	assign inj_mode_out = inj_mode_r;
	assign inj_target_out = active_inj_r[INJ_TGT_W-1:0];
endmodule
`default_nettype wire

// [cec_host.sv]
// Controller end: AHB-Lite registers that drive report reads and fault injection
`default_nettype none
module cec_host
	import cec_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	cec_if.host_mp             lnk,
	input  wire logic          hsel_in,
	input  wire logic [31:0]   haddr_in,
	input  wire logic [1:0]    htrans_in,
	input  wire logic          hwrite_in,
	input  wire logic [2:0]    hsize_in,
	input  wire logic          hready_in,
	input  wire logic [31:0]   hwdata_in,
	output logic [31:0]        hrdata_out,
	output logic               hreadyout_out,
	output logic               hresp_out,
	output logic               irq_out
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CAP   = 3'b001,
		ST_SHIFT = 3'b010,
		ST_UPD   = 3'b011,
		ST_DONE  = 3'b100
	} cec_hst_t;

	cec_hst_t          st_r;
	logic [2:0]        op_r;
	logic [5:0]        idx_r;
	logic [MSG_W-1:0]  buf_r;
	logic [INJ_W-1:0]  inj_r;
	logic [MSG_W-1:0]  jmsg_r;
	logic [MSG_W-1:0]  cmsg_r;
	logic [1:0]        stat_r;
	logic [1:0]        mask_r;
	logic              flag_d_r;
	logic              irq_r;
	logic [1:0]        instr_r;
	logic              jcap_r;
	logic              jshift_r;
	logic              jupd_r;
	logic              tdi_r;
	logic              ccap_r;
	logic              cshift_r;
	logic              wr_r;
	logic [7:0]        waddr_r;
	logic [31:0]       rdata_r;

	wire acc = hsel_in & hready_in & (htrans_in == HTRANS_NONSEQ);
	wire [7:0] ra = haddr_in[7:0];
	wire busy = st_r != ST_IDLE;
	wire wdp = wr_r;
	wire start = wdp & (waddr_r == OFS_CTRL) & ~busy & (|hwdata_in[2:0]);
	wire is_core = op_r[CTRL_CREAD];
	wire is_inj = op_r[CTRL_INJECT];
	wire [5:0] last_idx = is_inj ? 6'(INJ_W - 1) : 6'(MSG_W - 1);
	wire sh_bit = is_core ? lnk.csdo : lnk.tdo;
	wire flag_rise = lnk.upset_flag & ~flag_d_r;
	wire done_ev = st_r == ST_DONE;
	wire [1:0] ev = {done_ev, flag_rise};
	wire [1:0] clr = (wdp & (waddr_r == OFS_IRQ_STAT)) ? hwdata_in[1:0] : 2'b00;
	wire [31:0] rmux = (ra == OFS_CTRL) ? {30'h0, lnk.upset_flag, busy}
		: (ra == OFS_INJ) ? {11'h0, inj_r}
		: (ra == OFS_JMSG_LO) ? jmsg_r[31:0]
		: (ra == OFS_JMSG_HI) ? {18'h0, jmsg_r[MSG_W-1:32]}
		: (ra == OFS_CMSG_LO) ? cmsg_r[31:0]
		: (ra == OFS_CMSG_HI) ? {18'h0, cmsg_r[MSG_W-1:32]}
		: (ra == OFS_IRQ_STAT) ? {30'h0, stat_r}
		: (ra == OFS_IRQ_MASK) ? {30'h0, mask_r} : 32'h0;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_r <= 1'b0;
			waddr_r <= 8'h00;
			rdata_r <= 32'h0;
		end else begin
			wr_r <= acc & hwrite_in;
			waddr_r <= ra;
			if (acc & ~hwrite_in) begin
				rdata_r <= rmux;
			end
		end
	end

	// Sticky events, set wins over write-one clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stat_r <= 2'b00;
			mask_r <= 2'b00;
			flag_d_r <= 1'b0;
			irq_r <= 1'b0;
			inj_r <= {INJ_W{1'b0}};
		end else begin
			flag_d_r <= lnk.upset_flag;
			stat_r <= (stat_r & ~clr) | ev;
			irq_r <= |(stat_r & mask_r);
			if (wdp & (waddr_r == OFS_IRQ_MASK)) begin
				mask_r <= hwdata_in[1:0];
			end
			// setup only reaches device by instruction
			if (wdp & (waddr_r == OFS_INJ) & ~busy) begin
				inj_r <= hwdata_in[INJ_W-1:0];
			end
		end
	end

	// capture, shift, update sequence on the link
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= ST_IDLE;
			op_r <= 3'b000;
			idx_r <= 6'h00;
			buf_r <= {MSG_W{1'b0}};
			jmsg_r <= {MSG_W{1'b0}};
			cmsg_r <= {MSG_W{1'b0}};
			instr_r <= INSTR_NONE;
			jcap_r <= 1'b0;
			jshift_r <= 1'b0;
			jupd_r <= 1'b0;
			tdi_r <= 1'b0;
			ccap_r <= 1'b0;
			cshift_r <= 1'b0;
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					if (start) begin
						op_r <= hwdata_in[CTRL_INJECT] ? 3'b100 : hwdata_in[CTRL_JREAD] ? 3'b001 : 3'b010;
						instr_r <= hwdata_in[CTRL_INJECT] ? INSTR_load_fault_injection_instr
							: INSTR_read_error_message_instr;
						// test capture raised at once, only for a test read
						jcap_r <= ~hwdata_in[CTRL_INJECT] & hwdata_in[CTRL_JREAD];
						// core read uses its own path
						ccap_r <= ~hwdata_in[CTRL_INJECT] & ~hwdata_in[CTRL_JREAD];
						st_r <= ST_CAP;
					end
				end
				ST_CAP: begin
					jcap_r <= 1'b0;
					ccap_r <= 1'b0;
					jshift_r <= ~is_core;
					cshift_r <= is_core;
					tdi_r <= inj_r[0];
					idx_r <= 6'h00;
					st_r <= ST_SHIFT;
				end
				ST_SHIFT: begin
					buf_r <= {sh_bit, buf_r[MSG_W-1:1]};
					idx_r <= idx_r + 6'h01;
					tdi_r <= (idx_r < 6'(INJ_W - 1)) ? inj_r[5'(idx_r + 6'h01)] : 1'b0;
					if (idx_r == last_idx) begin
						jshift_r <= 1'b0;
						cshift_r <= 1'b0;
						jupd_r <= is_inj;
						st_r <= is_inj ? ST_UPD : ST_DONE;
					end
				end
				ST_UPD: begin
					jupd_r <= 1'b0;
					st_r <= ST_DONE;
				end
				ST_DONE: begin
					if (op_r[CTRL_JREAD]) begin
						jmsg_r <= buf_r;
					end
					if (is_core) begin
						cmsg_r <= buf_r;
					end
					instr_r <= INSTR_NONE;
					st_r <= ST_IDLE;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	assign lnk.instr = instr_r;
	assign lnk.jcap = jcap_r;
	assign lnk.jshift = jshift_r;
	assign lnk.jupd = jupd_r;
	assign lnk.tdi = tdi_r;
	assign lnk.ccap = ccap_r;
	assign lnk.cshift = cshift_r;
	assign hrdata_out = rdata_r;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign irq_out = irq_r;
endmodule
`default_nettype wire

// [cec_asserts.sv]
// Link protocol and flag spacing checks for the checker pair
`default_nettype none
module cec_asserts (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic [1:0] instr,
	input wire logic       jcap,
	input wire logic       jshift,
	input wire logic       jupd,
	input wire logic       ccap,
	input wire logic       cshift,
	input wire logic       upset_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] jrun_r;
	logic [5:0] crun_r;
	logic [6:0] low_r;
	// Run lengths of shifts and of the flag's low time
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			jrun_r <= 6'h00;
			crun_r <= 6'h00;
			low_r <= 7'h7F;
		end else begin
			jrun_r <= jshift ? jrun_r + 6'h01 : 6'h00;
			crun_r <= cshift ? crun_r + 6'h01 : 6'h00;
			low_r <= upset_flag ? 7'h00 : ((low_r == 7'h7F) ? low_r : low_r + 7'h01);
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_cap_read;
		jcap |-> (instr == 2'b01 && !jshift) ##1 (jshift && !jcap);
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("test capture out of order");
	property p_upd_inj;
		jupd |-> instr == 2'b10 ##1 !jupd;
	endproperty
	a_upd_inj: assert property (p_upd_inj) else $error("setup update out of order");
	property p_ccap;
		ccap |-> !cshift ##1 !ccap;
	endproperty
	a_ccap: assert property (p_ccap) else $error("core capture out of order");
	property p_jlen;
		$fell(jshift) |-> (instr == 2'b01 && jrun_r == 6'h2E) || (instr == 2'b10 && jrun_r == 6'h15);
	endproperty
	a_jlen: assert property (p_jlen) else $error("test shift length wrong");
	property p_clen;
		$fell(cshift) |-> crun_r == 6'h2E;
	endproperty
	a_clen: assert property (p_clen) else $error("core shift length wrong");
	property p_gap;
		$rose(upset_flag) |-> low_r >= 7'h3F;
	endproperty
	a_gap: assert property (p_gap) else $error("flag gap too short");
	property p_jshift_instr;
		jshift |-> instr != 2'b00 && $stable(instr);
	endproperty
	a_jshift_instr: assert property (p_jshift_instr) else $error("shift without instruction");
	property p_one_path;
		!(jshift && (cshift || ccap));
	endproperty
	a_one_path: assert property (p_one_path) else $error("both report paths busy");
	c_jread: cover property ($fell(jshift) && instr == 2'b01);
	c_inject: cover property (jupd);
	c_core: cover property ($fell(cshift));
	c_flag: cover property ($rose(upset_flag));
endmodule
`default_nettype wire

// [testbench.sv]
// Bench joining checker and controller over the link
`default_nettype none
module testbench
	import cec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk_in;
	logic                 rst_in;
	logic                 hsel;
	logic                 hwrite;
	logic                 hready;
	logic                 hresp;
	logic                 irq;
	logic                 chk_en;
	logic                 frame_done;
	logic                 search_done;
	logic [2:0]           hsize;
	logic [1:0]           htrans;
	logic [1:0]           inj_mode;
	logic [31:0]          haddr;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic [31:0]          rd;
	logic [SYN_W-1:0]     syn_in;
	logic [SYN_W-1:0]     syn_out;
	logic [TYPE_W-1:0]    etype;
	logic [LOC_W-1:0]     eloc;
	logic [INJ_TGT_W-1:0] inj_tgt;
	int                   fail_count = 0;
	int                   compares = 0;
	cec_if lnk ();
	cec_device u_cec_device (.clk_in(clk_in), .rst_in(rst_in), .lnk(lnk), .frame_done_in(frame_done),
		.syndrome_in(syn_in), .search_done_in(search_done), .err_type_in(etype), .err_loc_in(eloc),
		.chk_en_out(chk_en), .syndrome_out(syn_out), .inj_mode_out(inj_mode), .inj_target_out(inj_tgt));
	cec_host u_cec_host (.clk_in(clk_in), .rst_in(rst_in), .lnk(lnk), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .irq_out(irq));
	cec_asserts u_cec_asserts (.clk_in(clk_in), .rst_in(rst_in), .instr(lnk.instr), .jcap(lnk.jcap),
		.jshift(lnk.jshift), .jupd(lnk.jupd), .ccap(lnk.ccap), .cshift(lnk.cshift),
		.upset_flag(lnk.upset_flag));
	always #25 clk_in = ~clk_in;
	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One single AHB transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk_in);
		while (hready !== 1'b1) @(posedge clk_in);
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// Starts an operation and waits for its done bit, then clears it
	task automatic run_op(input logic [31:0] ctrl);
		bus(1'b1, OFS_CTRL, ctrl);
		for (int i = 0; i < 100; i++) begin
			bus(1'b0, OFS_IRQ_STAT, 32'h0);
			if (rd[IRQ_DONE] === 1'b1) break;
		end
		check(rd[IRQ_DONE], 1'b1);
		bus(1'b1, OFS_IRQ_STAT, 32'h2);
	endtask
	task automatic post(input logic [15:0] s, input logic [3:0] t, input logic [25:0] l);
		@(posedge clk_in);
		frame_done <= 1'b1;
		syn_in <= s;
		repeat (2) @(posedge clk_in);
		frame_done <= 1'b0;
		search_done <= 1'b1;
		etype <= t;
		eloc <= l;
		repeat (2) @(posedge clk_in);
		search_done <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
	endtask
	task automatic read_both(input logic [45:0] m);
		run_op(32'h1);
		rchk(OFS_JMSG_LO, m[31:0]);
		rchk(OFS_JMSG_HI, {18'h0, m[45:32]});
		run_op(32'h2);
		rchk(OFS_CMSG_LO, m[31:0]);
		rchk(OFS_CMSG_HI, {18'h0, m[45:32]});
	endtask
	task automatic t_regs;
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_IRQ_STAT, 32'h0);
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		rchk(8'h20, 32'h0);
		bus(1'b1, OFS_INJ, 32'hFFFFFFFF);
		rchk(OFS_INJ, 32'h001FFFFF);
		check({inj_mode, inj_tgt}, 64'h0);
		check(hresp, 1'b0);
		check(hready, 1'b1);
		// Check-rate enable must alternate on consecutive clocks
		@(posedge clk_in);
		#1;
		rd[0] = chk_en;
		@(posedge clk_in);
		#1;
		check(64'(rd[0]) + 64'(chk_en), 64'h1);
	endtask
	task automatic t_inject;
		logic [18:0] tg;
		for (int i = 0; i < 4; i++) begin
			tg = 19'h2A5C3 + 19'(i);
			bus(1'b1, OFS_INJ, {11'h0, 2'(i), tg});
			run_op(32'h4);
			check(inj_mode, (i == 3) ? 2'b00 : 2'(i));
			check(inj_tgt, tg);
		end
	endtask
	task automatic t_report(input logic [15:0] s, input logic [3:0] t, input logic [25:0] l);
		logic [45:0] m;
		m = {t, (t == ETYPE_SINGLE || t == ETYPE_DADJ) ? l : 26'h0, s};
		post(s, t, l);
		check(syn_out, s);
		check(lnk.upset_flag, 1'b1);
		read_both(m);
	endtask
	task automatic t_irq;
		rchk(OFS_IRQ_STAT, 32'h1);
		check(irq, 1'b0);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_in);
		check(irq, 1'b1);
		bus(1'b1, OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge clk_in);
		check(irq, 1'b0);
		bus(1'b1, OFS_IRQ_MASK, 32'h0);
	endtask
	task automatic t_zero;
		post(16'h0000, ETYPE_DADJ, 26'h0000055);
		check(lnk.upset_flag, 1'b0);
		read_both({ETYPE_SINGLE, 26'h1234567, 16'hBEEF});
	endtask
	initial begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hsize = 3'h2;
		frame_done = 1'b0;
		search_done = 1'b0;
		syn_in = 16'h0;
		etype = 4'h0;
		eloc = 26'h0;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_inject();
		t_report(16'hBEEF, ETYPE_SINGLE, 26'h1234567);
		t_irq();
		t_zero();
		repeat (80) @(posedge clk_in);
		t_report(16'h0001, 4'h3, 26'h3FFFFFF);
		final_report();
	end
	initial begin
		repeat (30000) @(posedge clk_in);
		fail_count++;
		final_report();
	end
endmodule
`default_nettype wire
